// >>> rtl/gigabit_reconciler.sv
// Contract
// - TXD bit 0 is LSB, sent first
// - RXD bit 0 is LSB, received first
// - TX_EN high only for valid frame bytes
// - Transmit pins change only with transmit clock
// - Transmit clock runs continuously
// - TX_ER only propagates errors, no extension
// - Add preamble and gap to every frame
// - Receive frame from SFD until RX_DV drops
// - Receive signals sampled by receive clock
// - Frame status ERROR if RX_DV with RX_ER
// - Ignore transmit length, give null receive length
// - Full duplex only, no CRS or COL
// - Provide link failure input
// - No degrade input, never report degrade
// - Strip preamble and gap on receive
// - Line runs at 1000 Mbps byte rate
// - Link status OK or FAIL from input
// - Not ready from acceptance through gap
`default_nettype none
module gigabit_reconciler (
  input  wire logic                                       ref_clk,
  input  wire logic                                       reset_n,
  input  wire logic [7:0]                                 tx_data,
  input  wire logic                                       tx_valid,
  input  wire logic                                       tx_last,
  input  wire logic                                       tx_error,
  input  wire logic [gigabit_reconciler_pkg::LENGTH_W-1:0] tx_length,
  output logic                                            tx_ready,
  output logic                                            tx_accept,
  output logic      [7:0]                                 rx_data,
  output logic                                            rx_valid,
  output logic                                            rx_last,
  output logic                                            rx_status_err,
  output logic      [gigabit_reconciler_pkg::LENGTH_W-1:0] rx_length,
  input  wire logic                                       rx_ready,
  input  wire logic                                       signal_fail,
  output logic                                            link_fail,
  output logic                                            gtx_clk,
  output logic      [7:0]                                 txd,
  output logic                                            tx_en,
  output logic                                            tx_er,
  input  wire logic                                       rx_clk,
  input  wire logic [7:0]                                 rxd,
  input  wire logic                                       rx_dv,
  input  wire logic                                       rx_er
);
  import gigabit_reconciler_pkg::*;

  // Reset release.
  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Pin synchronisers. The first stage feeds only the second stage.
  logic [SY_W-1:0] pin_meta_r;
  logic [SY_W-1:0] pin_sync_r;
  logic            rx_clk_prev_r;
  logic            rx_edge;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_r    <= '0;
      pin_sync_r    <= '0;
      rx_clk_prev_r <= 1'b0;
    end else begin
      pin_meta_r    <= {signal_fail, rx_clk, rx_er, rx_dv, rxd};
      pin_sync_r    <= pin_meta_r;
      rx_clk_prev_r <= pin_sync_r[SY_CLK];
    end
  end

  // Data and clock pass the same two stages, so the data seen at a
  // detected rising edge is the data the PHY set up for that edge.
  assign rx_edge = pin_sync_r[SY_CLK] && !rx_clk_prev_r;

  // Link status. There is no degrade input and no degrade output.
  logic link_fail_r;
  logic link_fail_nxt;

  always_comb begin
    link_fail_nxt = pin_sync_r[SY_FAIL];
  end

  // Transmit byte clock. The line runs one byte per BYTE_CYCLES.
  logic [1:0] phase_r;
  logic [1:0] phase_nxt;
  logic       gtx_clk_r;
  logic       gtx_clk_nxt;
  logic       tick;

  always_comb begin
    tick        = (phase_r == BYTE_LAST);
    phase_nxt   = tick ? 2'h0 : phase_r + 2'h1;
    // The clock falls on the tick, so the PHY samples mid-byte.
    gtx_clk_nxt = (phase_nxt >= BYTE_HALF);
  end

  // Transmit state machine.
  tx_state_t  tx_state_r;
  tx_state_t  tx_state_nxt;
  logic [3:0] tx_cnt_r;
  logic [3:0] tx_cnt_nxt;
  logic [7:0] txd_r;
  logic [7:0] txd_nxt;
  logic       tx_en_r;
  logic       tx_en_nxt;
  logic       tx_er_r;
  logic       tx_er_nxt;
  logic       tx_ready_r;
  logic       tx_ready_nxt;
  logic       tx_accept_r;
  logic       tx_accept_nxt;

  // tx_length is not read: the length of a frame is set by tx_last.
  always_comb begin
    tx_state_nxt  = tx_state_r;
    tx_cnt_nxt    = tx_cnt_r;
    txd_nxt       = txd_r;
    tx_en_nxt     = tx_en_r;
    tx_er_nxt     = tx_er_r;
    tx_accept_nxt = 1'b0;
    // The line pins move only on the tick, which is a transmit clock edge.
    if (tick) begin
      unique case (tx_state_r)
        TX_IDLE: begin
          txd_nxt   = 8'h00;
          tx_en_nxt = 1'b0;
          tx_er_nxt = 1'b0;
          if (tx_valid) begin
            txd_nxt      = PREAMBLE_BYTE;
            tx_en_nxt    = 1'b1;
            tx_cnt_nxt   = 4'h1;
            tx_state_nxt = TX_PRE;
          end
        end
        TX_PRE: begin
          tx_en_nxt = 1'b1;
          if (tx_cnt_r == PREAMBLE_LEN) begin
            txd_nxt      = SFD_BYTE;
            tx_state_nxt = TX_DATA;
          end else begin
            txd_nxt    = PREAMBLE_BYTE;
            tx_cnt_nxt = tx_cnt_r + 4'h1;
          end
        end
        TX_DATA: begin
          tx_en_nxt = 1'b1;
          if (tx_valid) begin
            txd_nxt       = tx_data;
            tx_er_nxt     = tx_error;
            tx_accept_nxt = 1'b1;
            if (tx_last) begin
              tx_cnt_nxt   = 4'h0;
              tx_state_nxt = TX_GAP;
            end
          end else begin
            // An underrun cannot be hidden: the frame is cut and marked.
            txd_nxt      = 8'h00;
            tx_er_nxt    = 1'b1;
            tx_cnt_nxt   = 4'h0;
            tx_state_nxt = TX_GAP;
          end
        end
        TX_GAP: begin
          txd_nxt    = 8'h00;
          tx_en_nxt  = 1'b0;
          tx_er_nxt  = 1'b0;
          tx_cnt_nxt = tx_cnt_r + 4'h1;
          if (tx_cnt_r == IPG_BYTES - 4'h1) begin
            tx_state_nxt = TX_IDLE;
          end
        end
      endcase
    end
    tx_ready_nxt = (tx_state_nxt == TX_IDLE);
  end

  // Receive state machine. One byte is held back so that the last byte
  // received before RX_DV drops can still be pushed with the last mark.
  rx_state_t  rx_state_r;
  rx_state_t  rx_state_nxt;
  logic [7:0] held_r;
  logic [7:0] held_nxt;
  logic       held_v_r;
  logic       held_v_nxt;
  logic       frame_err_r;
  logic       frame_err_nxt;
  logic [RX_WORD_W-1:0] push_word;
  logic                 push_valid;
  logic                 push_ready;
  logic [RX_WORD_W-1:0] pop_word;
  logic                 pop_valid;
  logic                 pop_ready;
  logic [7:0]           rx_byte;

  assign rx_byte = pin_sync_r[SY_RXD +: 8];

  always_comb begin
    rx_state_nxt  = rx_state_r;
    held_nxt      = held_r;
    held_v_nxt    = held_v_r;
    frame_err_nxt = frame_err_r;
    push_valid    = 1'b0;
    push_word     = '0;
    unique case (rx_state_r)
      RX_IDLE, RX_PRE: begin
        // Preamble and idle bytes are dropped here.
        if (rx_edge) begin
          if (!pin_sync_r[SY_DV]) begin
            rx_state_nxt = RX_IDLE;
          end else if (rx_byte == SFD_BYTE) begin
            rx_state_nxt  = RX_FRAME;
            held_v_nxt    = 1'b0;
            frame_err_nxt = 1'b0;
          end else begin
            rx_state_nxt = RX_PRE;
          end
        end
      end
      RX_FRAME: begin
        if (rx_edge) begin
          if (pin_sync_r[SY_DV]) begin
            if (pin_sync_r[SY_ER]) begin
              frame_err_nxt = 1'b1;
            end
            if (held_v_r) begin
              push_valid = 1'b1;
              push_word  = {1'b0, 1'b0, held_r};
              // A full buffer loses the byte; the frame is marked bad.
              if (!push_ready) begin
                frame_err_nxt = 1'b1;
              end
            end
            held_nxt   = rx_byte;
            held_v_nxt = 1'b1;
          end else begin
            rx_state_nxt = held_v_r ? RX_FLUSH : RX_IDLE;
          end
        end
      end
      RX_FLUSH: begin
        // The closing word is never dropped; it waits for room. The
        // gap on the line gives time for the buffer to drain.
        push_valid = 1'b1;
        push_word  = {frame_err_r, 1'b1, held_r};
        if (push_ready) begin
          held_v_nxt   = 1'b0;
          rx_state_nxt = RX_IDLE;
        end
      end
      default: begin
        rx_state_nxt = RX_IDLE;
      end
    endcase
  end

  word_fifo #(
    .WIDTH (RX_WORD_W),
    .DEPTH (RX_FIFO_DEP)
  ) rx_fifo (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .in_data   (push_word),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .out_data  (pop_word),
    .out_valid (pop_valid),
    .out_ready (pop_ready)
  );

  // Output register toward the MAC.
  logic [7:0] rx_data_r;
  logic [7:0] rx_data_nxt;
  logic       rx_valid_r;
  logic       rx_valid_nxt;
  logic       rx_last_r;
  logic       rx_last_nxt;
  logic       rx_err_r;
  logic       rx_err_nxt;

  assign pop_ready = !rx_valid_r || rx_ready;

  always_comb begin
    rx_data_nxt  = rx_data_r;
    rx_valid_nxt = rx_valid_r;
    rx_last_nxt  = rx_last_r;
    rx_err_nxt   = rx_err_r;
    if (pop_ready) begin
      rx_valid_nxt = pop_valid;
      if (pop_valid) begin
        rx_data_nxt = pop_word[7:0];
        rx_last_nxt = pop_word[RX_W_LAST];
        rx_err_nxt  = pop_word[RX_W_ERR];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_fail_r  <= 1'b0;
      phase_r      <= 2'h0;
      gtx_clk_r    <= 1'b0;
      tx_state_r   <= TX_IDLE;
      tx_cnt_r     <= 4'h0;
      txd_r        <= 8'h00;
      tx_en_r      <= 1'b0;
      tx_er_r      <= 1'b0;
      tx_ready_r   <= 1'b1;
      tx_accept_r  <= 1'b0;
      rx_state_r   <= RX_IDLE;
      held_r       <= 8'h00;
      held_v_r     <= 1'b0;
      frame_err_r  <= 1'b0;
      rx_data_r    <= 8'h00;
      rx_valid_r   <= 1'b0;
      rx_last_r    <= 1'b0;
      rx_err_r     <= 1'b0;
    end else begin
      link_fail_r  <= link_fail_nxt;
      phase_r      <= phase_nxt;
      gtx_clk_r    <= gtx_clk_nxt;
      tx_state_r   <= tx_state_nxt;
      tx_cnt_r     <= tx_cnt_nxt;
      txd_r        <= txd_nxt;
      tx_en_r      <= tx_en_nxt;
      tx_er_r      <= tx_er_nxt;
      tx_ready_r   <= tx_ready_nxt;
      tx_accept_r  <= tx_accept_nxt;
      rx_state_r   <= rx_state_nxt;
      held_r       <= held_nxt;
      held_v_r     <= held_v_nxt;
      frame_err_r  <= frame_err_nxt;
      rx_data_r    <= rx_data_nxt;
      rx_valid_r   <= rx_valid_nxt;
      rx_last_r    <= rx_last_nxt;
      rx_err_r     <= rx_err_nxt;
    end
  end

  // The block has no carrier sense or collision pins at all.
  assign link_fail     = link_fail_r;
  assign gtx_clk       = gtx_clk_r;
  assign txd           = txd_r;
  assign tx_en         = tx_en_r;
  assign tx_er         = tx_er_r;
  assign tx_ready      = tx_ready_r;
  assign tx_accept     = tx_accept_r;
  assign rx_data       = rx_data_r;
  assign rx_valid      = rx_valid_r;
  assign rx_last       = rx_last_r;
  assign rx_status_err = rx_err_r;
  // The delivered length is always null.
  assign rx_length     = '0;

endmodule : gigabit_reconciler
`default_nettype wire

// >>> rtl/gigabit_reconciler_pkg.sv
`default_nettype none
package gigabit_reconciler_pkg;

  // Clock and line timing.
  localparam int REF_CLK_MHZ    = 250;
  localparam int LINE_RATE_MBPS = 1000;
  localparam int BYTE_TIME_NS   = 8 * 1000 / LINE_RATE_MBPS;
  localparam int BYTE_CYCLES_I  = BYTE_TIME_NS * REF_CLK_MHZ / 1000;
  localparam logic [1:0] BYTE_CYCLES = 2'(BYTE_CYCLES_I);
  localparam logic [1:0] BYTE_LAST   = 2'(BYTE_CYCLES_I - 1);
  localparam logic [1:0] BYTE_HALF   = 2'(BYTE_CYCLES_I / 2);

  // Framing.
  localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE      = 8'hD5;
  localparam logic [3:0] PREAMBLE_LEN  = 4'h7;
  localparam logic [3:0] IPG_BYTES     = 4'hC;

  // Receive word layout in the FIFO.
  localparam int RX_WORD_W   = 10;
  localparam int RX_W_LAST   = 8;
  localparam int RX_W_ERR    = 9;
  localparam int RX_FIFO_DEP = 8;
  localparam int LENGTH_W    = 16;

  // Input synchroniser bit positions.
  localparam int SY_RXD   = 0;
  localparam int SY_DV    = 8;
  localparam int SY_ER    = 9;
  localparam int SY_CLK   = 10;
  localparam int SY_FAIL  = 11;
  localparam int SY_W     = 12;

  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_PRE  = 4'b0010,
    TX_DATA = 4'b0100,
    TX_GAP  = 4'b1000
  } tx_state_t;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_PRE   = 4'b0010,
    RX_FRAME = 4'b0100,
    RX_FLUSH = 4'b1000
  } rx_state_t;

endpackage : gigabit_reconciler_pkg
`default_nettype wire

// >>> rtl/word_fifo.sv
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  // DEPTH must be a power of two so the pointers wrap on their own.
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r   [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0]    wr_ptr_r, wr_ptr_nxt;
  logic [AW-1:0]    rd_ptr_r, rd_ptr_nxt;
  logic [AW:0]      count_r,  count_nxt;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];

  always_comb begin
    push       = in_valid && in_ready;
    pop        = out_valid && out_ready;
    mem_nxt    = mem_r;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt  = count_r;
    if (push) begin
      mem_nxt[wr_ptr_r] = in_data;
      wr_ptr_nxt        = wr_ptr_r + 1'b1;
    end
    if (pop) begin
      rd_ptr_nxt = rd_ptr_r + 1'b1;
    end
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_r    <= '{default: '0};
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      mem_r    <= mem_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r  <= count_nxt;
    end
  end

endmodule : word_fifo
`default_nettype wire

// >>> verif/gigabit_reconciler_asserts.sv
`default_nettype none
module reconciler_checker
  import gigabit_reconciler_pkg::*;
(
  input wire logic                                        ref_clk,
  input wire logic                                        reset_n,
  input wire logic                                        tx_ready,
  input wire logic                                        tx_accept,
  input wire logic [7:0]                                  txd,
  input wire logic                                        tx_en,
  input wire logic                                        tx_er,
  input wire logic                                        gtx_clk,
  input wire logic                                        signal_fail,
  input wire logic                                        link_fail,
  input wire logic [gigabit_reconciler_pkg::LENGTH_W-1:0] rx_length,
  input wire logic [7:0]                                  rx_data,
  input wire logic                                        rx_valid,
  input wire logic                                        rx_last,
  input wire logic                                        rx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] up_r;
  logic [2:0] up_nxt;
  logic [4:0] idle_r;
  logic [4:0] idle_nxt;

  // The idle count starts saturated so the first frame is not held to a gap.
  always_comb begin
    up_nxt = (up_r == 3'h7) ? up_r : up_r + 3'h1;
    idle_nxt = tx_en ? 5'h00 : ((idle_r == 5'h1F) ? idle_r : idle_r + 5'h01);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      up_r <= 3'h0;
      idle_r <= 5'h1F;
    end else begin
      up_r <= up_nxt;
      idle_r <= idle_nxt;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_gtx_clk_runs: assert property (
    up_r == 3'h7 |-> gtx_clk != $past(gtx_clk))
    else $error("transmit clock stopped");
  a_tx_pins_sync: assert property (
    up_r == 3'h7 && !$fell(gtx_clk) |-> $stable({txd, tx_en, tx_er}))
    else $error("transmit pins moved off the clock");
  a_er_needs_en: assert property (tx_er |-> tx_en)
    else $error("error strobe outside a frame");
  a_accept_in_frame: assert property (tx_accept |-> tx_en)
    else $error("byte taken while enable low");
  a_en_not_ready: assert property (tx_en |-> !tx_ready)
    else $error("ready shown during a frame");
  a_gap_min_len: assert property (
    $rose(tx_en) |-> idle_r >= 5'h18)
    else $error("interframe gap too short");
  a_preamble_form: assert property (
    $rose(tx_en) |-> txd == PREAMBLE_BYTE ##12 txd == PREAMBLE_BYTE
    ##2 txd == SFD_BYTE && !tx_er)
    else $error("bad preamble");
  a_ready_after_gap: assert property (
    $fell(tx_en) |-> !tx_ready ##20 !tx_ready ##2 tx_ready)
    else $error("ready at wrong time after frame");
  a_link_follows: assert property (
    up_r == 3'h7 |-> link_fail == $past(signal_fail, 3))
    else $error("link status does not follow input");
  a_rx_len_null: assert property (rx_length == '0)
    else $error("receive length not null");
  a_rx_word_holds: assert property (
    rx_valid && !rx_ready |=> rx_valid && $stable({rx_data, rx_last}))
    else $error("receive word dropped while stalled");

  c_frame_start: cover property ($rose(tx_en));
  c_tx_error: cover property (tx_er);
  c_rx_end: cover property (rx_valid && rx_ready && rx_last);
  c_link_down: cover property ($rose(link_fail));
endmodule : reconciler_checker

bind gigabit_reconciler reconciler_checker u_chk (
  .ref_clk, .reset_n, .tx_ready, .tx_accept, .txd, .tx_en, .tx_er,
  .gtx_clk, .signal_fail, .link_fail, .rx_length, .rx_data, .rx_valid,
  .rx_last, .rx_ready
);
`default_nettype wire

// >>> verif/phy_model.sv
`default_nettype none
module phy_model (
  input  wire logic       gtx_clk,
  input  wire logic [7:0] txd,
  input  wire logic       tx_en,
  input  wire logic       tx_er,
  output logic            rx_clk,
  output logic      [7:0] rxd,
  output logic            rx_dv,
  output logic            rx_er
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] tx_q[$];

  initial begin
    rx_clk = 1'b0;
    rxd = 8'h00;
    rx_dv = 1'b0;
    rx_er = 1'b0;
  end

  // Gap bytes are not kept; the gap length is judged by the checker.
  always @(posedge gtx_clk)
    if (tx_en === 1'b1) tx_q.push_back({tx_er, txd});

  task automatic put(input logic [7:0] b, input logic dv, input logic er);
    rxd = b;
    rx_dv = dv;
    rx_er = er;
    #32 rx_clk = 1'b1;
    #32 rx_clk = 1'b0;
  endtask : put

  // The receive clock runs only within a frame and a short tail after it,
  // and the released data line toggles so a stale byte is never mistaken.
  task automatic send(input logic [7:0] d[$], input int bad);
    #3;
    repeat (7) put(8'h55, 1'b1, 1'b0);
    put(8'hD5, 1'b1, 1'b0);
    foreach (d[i]) put(d[i], 1'b1, i == bad);
    repeat (3) put(~rxd, 1'b0, 1'b0);
  endtask : send
endmodule : phy_model
`default_nettype wire

// >>> verif/gigabit_reconciler_tb_top.sv
`default_nettype none
module gigabit_reconciler_tb_top import gigabit_reconciler_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic                ref_clk, reset_n, tx_valid, tx_last, tx_error;
  logic                tx_ready, tx_accept, rx_valid, rx_last, rx_ready;
  logic                rx_status_err, signal_fail, link_fail, gtx_clk;
  logic                tx_en, tx_er, rx_clk, rx_dv, rx_er, stall;
  logic [7:0]          tx_data, rx_data, txd, rxd;
  logic [LENGTH_W-1:0] tx_length, rx_length;
  logic [31:0]         seed = 32'h0000_7E5F;
  logic [8:0]          exq[$];
  logic [9:0]          rxq[$], gotq[$];
  int                  fail_count = 0;
  int                  compares = 0;

  gigabit_reconciler u_dut (
    .ref_clk, .reset_n, .tx_data, .tx_valid, .tx_last, .tx_error,
    .tx_length, .tx_ready, .tx_accept, .rx_data, .rx_valid, .rx_last,
    .rx_status_err, .rx_length, .rx_ready, .signal_fail, .link_fail,
    .gtx_clk, .txd, .tx_en, .tx_er, .rx_clk, .rxd, .rx_dv, .rx_er
  );
  phy_model u_phy (
    .gtx_clk, .txd, .tx_en, .tx_er, .rx_clk, .rxd, .rx_dv, .rx_er
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize();
    if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  task automatic tx_frame(input int n, input int bad);
    logic [7:0] b;
    int         w;
    for (w = 0; w < 64 && tx_ready !== 1'b1; w++) @(posedge ref_clk);
    repeat (7) exq.push_back(9'h055);
    exq.push_back(9'h0D5);
    for (int k = 0; k < n; k++) begin
      b = 8'(rnd());
      exq.push_back({k == bad, b});
      tx_valid <= 1'b1;
      tx_data <= b;
      tx_last <= (k == n - 1) && (bad != n);
      tx_error <= (k == bad);
      tx_length <= LENGTH_W'(rnd());
      @(posedge ref_clk);
      for (w = 0; w < 64 && tx_accept !== 1'b1; w++) @(posedge ref_clk);
    end
    // An error index equal to the length starves the frame instead, so
    // the line must close it with one marked filler byte.
    if (bad == n) exq.push_back(9'h100);
    tx_valid <= 1'b0;
    tx_last <= 1'b0;
    tx_error <= 1'b0;
  endtask : tx_frame

  // Only the last word carries a meaningful status, so it alone expects one.
  task automatic rx_frame(input int n, input int bad);
    logic [7:0] d[$];
    logic       err;
    err = (bad >= 0 && bad < n);
    for (int i = 0; i < n; i++) begin
      d.push_back(8'(rnd()));
      if (!stall) rxq.push_back({i == n - 1 && err, i == n - 1, d[i]});
    end
    u_phy.send(d, bad);
    repeat (40) @(posedge ref_clk);
  endtask : rx_frame

  task automatic rx_cmp();
    chk(16'(gotq.size()), 16'(rxq.size()));
    while (gotq.size() > 0 && rxq.size() > 0)
      chk(16'(gotq.pop_front()), 16'(rxq.pop_front()));
    rxq.delete();
    gotq.delete();
  endtask : rx_cmp

  always @(posedge ref_clk) begin
    rx_ready <= !stall && (rnd() % 2 != 0);
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
      gotq.push_back({rx_last & rx_status_err, rx_last, rx_data});
  end

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    summarize();
  end

  initial begin
    reset_n = 1'b0;
    stall = 1'b0;
    tx_valid = 1'b0;
    tx_last = 1'b0;
    tx_error = 1'b0;
    tx_data = 8'h00;
    tx_length = '0;
    rx_ready = 1'b0;
    signal_fail = 1'b0;
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    fork
      begin
        tx_frame(1, -1);
        tx_frame(6, 2);
        tx_frame(4, 0);
        tx_frame(3, 3);
        for (int f = 0; f < 6; f++) tx_frame(1 + int'(rnd() % 9), -1);
        repeat (40) @(posedge ref_clk);
        chk(16'(u_phy.tx_q.size()), 16'(exq.size()));
        while (u_phy.tx_q.size() > 0 && exq.size() > 0)
          chk(16'(u_phy.tx_q.pop_front()), 16'(exq.pop_front()));
      end
      begin
        rx_frame(0, -1);
        rx_frame(3, 0);
        rx_frame(5, 4);
        for (int f = 0; f < 5; f++)
          rx_frame(1 + int'(rnd() % 6), int'(rnd() % 8) - 1);
        rx_cmp();
        stall = 1'b1;
        rx_frame(12, -1);
        stall = 1'b0;
        repeat (60) @(posedge ref_clk);
        // The output word and a full buffer survive, plus the closing word.
        chk(16'(gotq.size()), 16'(RX_FIFO_DEP + 2));
        chk(16'(gotq[$][9:8]), 16'h0003);
        chk(16'(rx_valid), 16'h0000);
      end
    join
    for (int i = 0; i < 8; i++) begin
      signal_fail <= (rnd() % 2 != 0);
      @(posedge ref_clk);
      repeat (3) @(posedge ref_clk);
      chk(16'(link_fail), 16'(signal_fail));
    end
    summarize();
  end
endmodule : gigabit_reconciler_tb_top
`default_nettype wire
